// ==== rtl/sps_pkg.sv ====
// Package with constants and types for the servo link package scheduler.
package sps_pkg;

  // ****************************************************************
  // Clock and link timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 8;
  // Symbol rate 9.375 MBaud from 125 MHz is exactly 3 ticks per 40 clocks.
  localparam int BAUD_KBAUD     = 9375;
  localparam int BAUD_NUM       = 3;
  localparam int BAUD_DEN       = 40;
  // Package lengths in ns as printed.
  localparam int FREE_LEN_NS    = 11520;
  localparam int SYNC_MIN_NS    = 12200;
  localparam int SYNC_MAX_NS    = 27000;
  localparam int SINGLE_MAX_NS  = 26300;
  // Least times round up, longest times round down.
  localparam int FREE_LEN_CYC   = (FREE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MIN_CYC   = (SYNC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MAX_CYC   = SYNC_MAX_NS / CLK_PERIOD_NS;
  localparam int SINGLE_MAX_CYC = SINGLE_MAX_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Field widths and reset values
  // ****************************************************************
  localparam int CNT_W          = 16;
  localparam int ACC_W          = 23;
  localparam int DIV_W          = 6;
  localparam int SAFE_PKGS      = 8;
  localparam int SEQ_W          = 10;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [2:0]       SLOT_RST = 3'h0;
  localparam int FIFO_DEPTH     = 32;

  // Descriptor of one package handed to the serializer.
  typedef struct packed {
    logic             user_sync;
    logic             free_mode;
    logic             safe_first;
    logic [2:0]       safe_slot;
    logic [SEQ_W-1:0] seq;
  } sps_desc_t;

  localparam int DESC_W = $bits(sps_desc_t);

endpackage

// ==== rtl/sps_fifo.sv ====
// Synchronous FIFO with a registered output stage.
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             push, pop;

  // ****************************************************************
  // Pointer and output stage logic
  // ****************************************************************
  // The output register reloads whenever it is empty or being taken.
  always_comb begin
    push  = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop   = (cnt_q != '0) && (!ov_q || i_out_ready);
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ov_d  = pop ? 1'b1 : (i_out_ready ? 1'b0 : ov_q);
    od_d  = pop ? mem[rd_q] : od_q;
  end

  // Storage has no reset; only pointers and the valid flag need one.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = ov_q;
  assign o_out_data  = od_q;
endmodule

// ==== rtl/sps_scheduler.sv ====
// Package scheduler for the servo feedback link, inverter side.
//
// Operation
// - Link runs at 9.375 MBaud symbol rate.
// - Free running: ignore strobe, 11.52 us packages.
// - Sync mode: samples locked to strobe, jitter-free.
// - One sample per package, constant latency.
// - Extra packages per cycle from divider value.
// - Cycle 12.2..26.3 us: exactly one package.
// - Channel periods scale with package length.
// - Safe channels repeat every 92.16 us free running, 97.6..216 us in sync mode.
// - Every package refreshes fast position content.
// - Safe value spans eight packages, first sampled.
`timescale 1ns/1ps
module sps_scheduler #(
  parameter int DIV_WIDTH  = sps_pkg::DIV_W,
  parameter int FIFO_DEPTH = sps_pkg::FIFO_DEPTH
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_sync,
  input  wire logic                  i_sync_mode,
  input  wire logic [DIV_WIDTH-1:0]  i_divider,
  input  wire logic                  i_desc_ready,
  output logic                       o_desc_valid,
  output sps_pkg::sps_desc_t         o_desc,
  output logic                       o_pkg_start,
  output logic                       o_sample,
  output logic                       o_baud_tick,
  output logic                       o_range_err,
  output logic [sps_pkg::CNT_W-1:0]  o_cycle_len
);
  import sps_pkg::*;

  // ****************************************************************
  // Strobe input synchroniser
  // ****************************************************************
  logic [2:0] sy_q, sy_d;
  logic       lvl_q, lvl_d;
  logic       edge_c;

  // A rising change counts only once the second and third stages agree.
  always_comb begin
    sy_d   = {sy_q[1:0], i_sync};
    edge_c = (sy_q[2] == sy_q[1]) && (sy_q[2] != lvl_q) && sy_q[2];
    lvl_d  = (sy_q[2] == sy_q[1]) ? sy_q[2] : lvl_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sy_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sy_q  <= sy_d;
      lvl_q <= lvl_d;
    end
  end

  // ****************************************************************
  // Package timing
  // ****************************************************************
  logic [CNT_W-1:0]     cyc_cnt_q, cyc_cnt_d;
  logic [CNT_W-1:0]     cyc_len_q, cyc_len_d;
  logic [CNT_W-1:0]     pkg_cnt_q, pkg_cnt_d;
  logic [ACC_W-1:0]     acc_q, acc_d;
  logic [DIV_WIDTH-1:0] ext_q, ext_d;
  logic [DIV_WIDTH-1:0] n_eff;
  logic [2:0]           slot_q, slot_d;
  logic [SEQ_W-1:0]     seq_q, seq_d;
  logic                 pend_q, pend_d;
  logic                 pusr_q, pusr_d;
  logic                 err_q, err_d;
  logic                 start_q, start_d;
  logic                 want, want_usr, start_c;
  logic                 fifo_ready;
  sps_desc_t            desc_c;

  always_comb begin
    // Short cycles carry one package; longer ones use the divider.
    n_eff = (cyc_len_q <= CNT_W'(SINGLE_MAX_CYC) || i_divider == '0)
            ? DIV_WIDTH'(1) : i_divider;
    cyc_cnt_d = (cyc_cnt_q == '1) ? cyc_cnt_q : cyc_cnt_q + 1'b1;
    cyc_len_d = cyc_len_q;
    acc_d     = acc_q;
    ext_d     = ext_q;
    want      = 1'b0;
    want_usr  = 1'b0;
    if (!i_sync_mode) begin
      // Back to back minimum-length packages, strobe ignored.
      want = (pkg_cnt_q >= CNT_W'(FREE_LEN_CYC - 1));
    end else if (edge_c) begin
      // The strobe edge starts a package at once, no timing slip.
      want      = 1'b1;
      want_usr  = 1'b1;
      // Saturate rather than wrap, so a very long gap never reads as no cycle at all.
      cyc_len_d = (cyc_cnt_q == '1) ? cyc_cnt_q : cyc_cnt_q + 1'b1;
      cyc_cnt_d = '0;
      acc_d     = '0;
      ext_d     = '0;
    end else if (cyc_len_q != '0 && ext_q < n_eff - 1'b1) begin
      // Accumulate divider per clock; equal spacing without a divide.
      acc_d = acc_q + ACC_W'(n_eff);
      if (acc_d >= ACC_W'(cyc_len_q)) begin
        acc_d = acc_d - ACC_W'(cyc_len_q);
        ext_d = ext_q + 1'b1;
        want  = 1'b1;
      end
    end
    // A full FIFO holds the start back until the serializer drains.
    start_c = (want || pend_q) && fifo_ready;
    pend_d  = (want || pend_q) && !fifo_ready;
    pusr_d  = pend_d ? (pusr_q || want_usr) : 1'b0;
    start_d = start_c;
    pkg_cnt_d = start_c ? '0 : pkg_cnt_q + 1'b1;
    // Check the finished package against the sync-mode range.
    err_d = err_q;
    if (start_c && i_sync_mode) begin
      err_d = (pkg_cnt_q + 1'b1 < CNT_W'(SYNC_MIN_CYC)) ||
              (pkg_cnt_q + 1'b1 > CNT_W'(SYNC_MAX_CYC));
    end else if (!i_sync_mode) begin
      err_d = 1'b0;
    end
    // Safe slots cycle over eight packages, so periods follow length.
    slot_d = start_c ? slot_q + 1'b1 : slot_q;
    seq_d  = start_c ? seq_q + 1'b1 : seq_q;
    desc_c.user_sync  = want_usr || pusr_q;
    desc_c.free_mode  = !i_sync_mode;
    desc_c.safe_first = (slot_q == 3'h0);
    desc_c.safe_slot  = slot_q;
    desc_c.seq        = seq_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cyc_cnt_q <= CNT_RST;
      cyc_len_q <= CNT_RST;
      pkg_cnt_q <= CNT_RST;
      acc_q     <= '0;
      ext_q     <= '0;
      slot_q    <= SLOT_RST;
      seq_q     <= '0;
      pend_q    <= 1'b0;
      pusr_q    <= 1'b0;
      err_q     <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      cyc_cnt_q <= cyc_cnt_d;
      cyc_len_q <= cyc_len_d;
      pkg_cnt_q <= pkg_cnt_d;
      acc_q     <= acc_d;
      ext_q     <= ext_d;
      slot_q    <= slot_d;
      seq_q     <= seq_d;
      pend_q    <= pend_d;
      pusr_q    <= pusr_d;
      err_q     <= err_d;
      start_q   <= start_d;
    end
  end

  // ****************************************************************
  // Symbol clock
  // ****************************************************************
  logic [5:0] bacc_q, bacc_d;
  logic       btick_q, btick_d;

  // Fractional 3/40 step; realigned at each package start.
  always_comb begin
    bacc_d  = bacc_q + 6'(BAUD_NUM);
    btick_d = 1'b0;
    if (start_c) begin
      bacc_d  = 6'h00;
      btick_d = 1'b1;
    end else if (bacc_d >= 6'(BAUD_DEN)) begin
      bacc_d  = bacc_d - 6'(BAUD_DEN);
      btick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bacc_q  <= 6'h00;
      btick_q <= 1'b0;
    end else begin
      bacc_q  <= bacc_d;
      btick_q <= btick_d;
    end
  end

  // ****************************************************************
  // Descriptor buffer
  // ****************************************************************
  sps_fifo #(
    .WIDTH (DESC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (start_c),
    .o_in_ready  (fifo_ready),
    .i_in_data   (desc_c),
    .o_out_valid (o_desc_valid),
    .i_out_ready (i_desc_ready),
    .o_out_data  (o_desc)
  );

  // Every package start is also the fast position sample instant.
  assign o_pkg_start = start_q;
  assign o_sample    = start_q;
  assign o_baud_tick = btick_q;
  assign o_range_err = err_q;
  assign o_cycle_len = cyc_len_q;
endmodule

// ==== verification/sps_scheduler_properties.sv ====
// Port checker for the package scheduler.
`timescale 1ns/1ps
module sps_checker (
  input wire logic               i_clk,
  input wire logic               i_reset,
  input wire logic               i_sync,
  input wire logic               i_sync_mode,
  input wire logic               i_desc_ready,
  input wire logic               o_desc_valid,
  input wire sps_pkg::sps_desc_t o_desc,
  input wire logic               o_pkg_start,
  input wire logic               o_sample,
  input wire logic               o_baud_tick,
  input wire logic               o_range_err
);
  import sps_pkg::*;
  // ****
  // Helper state and assertions
  // ****
  logic [15:0]      gap_q;
  logic             void_q;
  logic             have_q;
  logic [SEQ_W-1:0] seq_q;
  logic [2:0]       slot_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // A strobe mode or a stalled handoff voids the free gap, since backlog releases come late.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gap_q  <= 16'hFFFF;
      void_q <= 1'b1;
      have_q <= 1'b0;
    end else begin
      gap_q  <= o_pkg_start ? 16'h0001 : gap_q + {15'h0000, gap_q != 16'hFFFF};
      void_q <= (o_pkg_start ? 1'b0 : void_q) | i_sync_mode | (o_desc_valid & ~i_desc_ready);
      if (o_desc_valid && i_desc_ready) begin
        have_q <= 1'b1;
        seq_q  <= o_desc.seq;
        slot_q <= o_desc.safe_slot;
      end
    end
  end
  sample_at_start_a: assert property (o_sample == o_pkg_start)
    else $error("sample pulse apart from start");
  start_tick_a: assert property (o_pkg_start |-> o_baud_tick)
    else $error("start off the symbol grid");
  free_gap_a: assert property (o_pkg_start && !void_q |-> gap_q >= FREE_LEN_CYC)
    else $error("free package too short");
  strobe_lat_a: assert property (i_sync_mode && $rose(i_sync) |-> ##4 (o_pkg_start && o_sample))
    else $error("no start after strobe");
  range_free_a: assert property (!i_sync_mode && !$past(i_sync_mode) && !$past(i_sync_mode, 2) |-> !o_range_err)
    else $error("range flag in free mode");
  seq_step_a: assert property (o_desc_valid && i_desc_ready && have_q |-> o_desc.seq == SEQ_W'(seq_q + 1'b1))
    else $error("sequence skipped");
  slot_step_a: assert property (o_desc_valid && i_desc_ready && have_q |-> o_desc.safe_slot == slot_q + 3'h1)
    else $error("safe slot skipped");
  safe_first_a: assert property (o_desc_valid |-> o_desc.safe_first == (o_desc.safe_slot == 3'h0))
    else $error("safe first flag wrong");
  desc_hold_a: assert property (o_desc_valid && !i_desc_ready |=> o_desc_valid && $stable(o_desc))
    else $error("descriptor dropped");
  // Descriptors seen well inside free mode were built there and never carry a strobe mark.
  mode_flag_a: assert property (o_desc_valid && !i_sync_mode && !$past(i_sync_mode, 4)
    |-> o_desc.free_mode && !o_desc.user_sync)
    else $error("free descriptor flags wrong");
  cover property (o_pkg_start && i_sync_mode);
  cover property (o_desc_valid && i_desc_ready && !o_desc.user_sync && !o_desc.free_mode);
  cover property (o_range_err);
  cover property (o_desc_valid && !i_desc_ready);
endmodule
bind sps_scheduler sps_checker u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_sync(i_sync), .i_sync_mode(i_sync_mode), .i_desc_ready(i_desc_ready),
  .o_desc_valid(o_desc_valid), .o_desc(o_desc), .o_pkg_start(o_pkg_start), .o_sample(o_sample),
  .o_baud_tick(o_baud_tick), .o_range_err(o_range_err)
);

// ==== verification/sps_serializer_model.sv ====
// Behavioural serializer that consumes package descriptors.
`timescale 1ns/1ps
module sps_serializer_model (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_hold,
  input  wire logic i_baud_tick,
  input  wire logic i_desc_valid,
  output logic      o_ready,
  output int        o_taken
);
  // ****
  // Handoff
  // ****
  int busy;
  assign o_ready = !i_hold && busy == 0;
  // Each descriptor costs eight symbol times, well inside one package.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy    <= 0;
      o_taken <= 0;
    end else if (i_desc_valid && o_ready) begin
      busy    <= 8;
      o_taken <= o_taken + 1;
    end else if (busy > 0 && i_baud_tick) begin
      busy <= busy - 1;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the package scheduler.
`timescale 1ns/1ps
module tb_top;
  import sps_pkg::*;
  // ****
  // Stimulus, watcher and verdict
  // ****
  logic             i_clk, i_reset, i_sync, i_sync_mode, hold, noise, skip, ready;
  logic             o_desc_valid, o_pkg_start, o_sample, o_baud_tick, o_range_err;
  logic [5:0]       i_divider;
  logic [CNT_W-1:0] o_cycle_len;
  sps_desc_t        o_desc;
  logic [31:0]      lfsr;
  int               n_mismatch, check_count, cyc, last_t, ticks, starts, total, taken, exp_gap;
  int               q[$];
  int               cfg_p[5] = '{6000, 2000, 3287, 3288, 3400};
  int               cfg_n[5] = '{3, 4, 2, 2, 4};
  sps_scheduler dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sync(i_sync), .i_sync_mode(i_sync_mode), .i_divider(i_divider),
    .i_desc_ready(ready), .o_desc_valid(o_desc_valid), .o_desc(o_desc), .o_pkg_start(o_pkg_start),
    .o_sample(o_sample), .o_baud_tick(o_baud_tick), .o_range_err(o_range_err), .o_cycle_len(o_cycle_len)
  );
  sps_serializer_model u_ser (
    .i_clk(i_clk), .i_reset(i_reset), .i_hold(hold), .i_baud_tick(o_baud_tick),
    .i_desc_valid(o_desc_valid), .o_ready(ready), .o_taken(taken)
  );
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_int(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("Error t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expire();
    n_mismatch++;
    $display("Error t=%0t wait ran out", $time);
    complete_run();
  endtask
  task automatic wait_q(input int lim);
    for (int k = 0; k < lim && q.size() > 0; k++) @(negedge i_clk);
    if (q.size() > 0) expire();
  endtask
  // Strobe mode: the first cycle after entry takes its length from before entry and spawns no extras, so extras start in the second.
  task automatic run_sync(input int p, input int n);
    logic multi;
    multi = p > SINGLE_MAX_CYC && n > 1;
    i_sync = 1'b0;
    i_sync_mode = 1'b0;
    q.delete();
    repeat (2) @(negedge i_clk);
    i_sync_mode = 1'b1;
    i_divider = n[5:0];
    repeat (4) @(negedge i_clk);
    q.push_back(p);
    repeat (multi ? n : 1) q.push_back(multi ? p / n : p);
    skip = 1'b1;
    for (int k = 0; k < 3; k++) begin
      i_sync = 1'b1;
      repeat (8) @(negedge i_clk);
      i_sync = 1'b0;
      if (k < 2) repeat (p - 8) @(negedge i_clk);
    end
    wait_q(60);
    repeat (4) @(negedge i_clk);
    chk_vec(o_cycle_len, p[15:0]);
    chk_vec({15'h0000, o_range_err}, {15'h0000, multi && p / n < SYNC_MIN_CYC});
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Free-mode noise on the strobe and divider, which must both be ignored.
  always @(negedge i_clk) begin
    if (noise) begin
      lfsr = step(lfsr);
      i_sync <= lfsr[0];
      i_divider <= lfsr[6:1];
    end
  end
  // Each start while skip is clear takes the oldest expected spacing; an empty queue means no claim.
  always @(posedge i_clk) begin
    cyc++;
    if (o_baud_tick === 1'b1) ticks++;
    if (o_pkg_start === 1'b1) begin
      starts++;
      total++;
      if (!skip && q.size() > 0) begin
        exp_gap = q.pop_front();
        chk_int(cyc - last_t, exp_gap);
        if (exp_gap == FREE_LEN_CYC) chk_int(ticks, FREE_LEN_CYC * BAUD_NUM / BAUD_DEN);
      end
      skip = 1'b0;
      last_t = cyc;
      ticks = 0;
    end
  end
  initial begin
    {n_mismatch, check_count, cyc, last_t, ticks, starts, total} = '0;
    lfsr = 32'h05756923;
    {i_reset, skip} = 2'h3;
    {i_sync, i_sync_mode, hold, noise} = 4'h0;
    i_divider = 6'h01;
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    noise = 1'b1;
    repeat (4) q.push_back(FREE_LEN_CYC);
    wait_q(8000);
    // Stall the far side until the buffer refuses, then let it drain.
    hold = 1'b1;
    starts = 0;
    repeat (34 * FREE_LEN_CYC) @(negedge i_clk);
    chk_int(starts >= 32 && starts <= 34, 1);
    chk_vec({15'h0000, o_desc_valid}, 16'h0001);
    hold = 1'b0;
    for (int k = 0; k < 9000 && o_desc_valid !== 1'b0; k++) @(negedge i_clk);
    if (o_desc_valid !== 1'b0) expire();
    chk_int(taken, total);
    noise = 1'b0;
    // Let one falling edge pass, so a last random strobe value cannot land after the run has cleared it.
    @(negedge i_clk);
    foreach (cfg_p[i]) run_sync(cfg_p[i], cfg_n[i]);
    complete_run();
  end
endmodule
